// ### common/tef_pkg.sv
/*
 Shared constants and types for the translation entry block: register
 numbers, field positions, reset values and the stored entry layout.
 Assumes a 64-bit coprocessor move path and a 32-entry array.
*/
package tef_pkg;
    // ==========================================================
    // Register numbers
    localparam logic [4:0] NUM_INDEX  = 5'h00;
    localparam logic [4:0] NUM_RANDOM = 5'h01;
    localparam logic [4:0] NUM_LO0    = 5'h02;
    localparam logic [4:0] NUM_LO1    = 5'h03;
    localparam logic [4:0] NUM_MASK   = 5'h05;
    localparam logic [4:0] NUM_WIRED  = 5'h06;
    localparam logic [4:0] NUM_HI     = 5'h0A;
    localparam logic [4:0] NUM_PROCESSOR_IDENTIFICATION   = 5'h0F;
    localparam logic [4:0] NUM_CONFIG = 5'h10;
    localparam logic [4:0] NUM_LINK   = 5'h11;
    localparam logic [4:0] NUM_CACHE_TAG_LOW  = 5'h1C;
    localparam logic [4:0] NUM_CACHE_TAG_HIGH  = 5'h1D;
    // ==========================================================
    // Field positions
    localparam int HI_REGION_LSB = 62;
    localparam int HI_PAIRED_VIRTUAL_PAGE_LSB   = 13;
    localparam int MASK_LSB      = 13;
    localparam int LO_PFN_LSB    = 6;
    localparam int LO_C_LSB      = 3;
    localparam int LO_D_BIT      = 2;
    localparam int LO_V_BIT      = 1;
    localparam int LO_G_BIT      = 0;
    // ==========================================================
    // Codes, sizes and reset values
    localparam logic [2:0]  C_UNCACHED  = 3'h2;
    localparam logic [1:0]  REGION_USER = 2'h0;
    localparam logic [1:0]  REGION_SUPV = 2'h1;
    localparam logic [1:0]  REGION_KERN = 2'h3;
    localparam logic [4:0]  SCAN_LAST   = 5'h1F;
    localparam logic [5:0]  SCAN_START  = 6'h00;
    localparam logic [63:0] RST_DATA    = 64'h0;
    // ==========================================================
    // Types
    typedef struct packed {
        logic [19:0] page_frame_number;
        logic [2:0]  c;
        logic        d;
        logic        v;
        logic        g;
    } tef_lo_t;
    typedef struct packed {
        logic [11:0] mask;
        logic [1:0]  region;
        logic [26:0] paired_virtual_page;
        logic        g;
        logic [7:0]  address_space_identifier;
        tef_lo_t     lo0;
        tef_lo_t     lo1;
    } tef_entry_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SCAN = 2'b01,
        ST_READ = 2'b10
    } tef_state_e;
endpackage

// ### verilog/tef_mem.sv
/*
 Entry array: one write port, one read port whose data come from a
 register. Assumes the owner serialises array operations.
*/
`timescale 1ns/100ps
module tef_mem
    import tef_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       we,
    input  wire logic [4:0] waddr,
    input  tef_entry_t      wdata,
    input  wire logic [4:0] raddr,
    output tef_entry_t      rdata
);
    tef_entry_t mem [0:31];

    // ==========================================================
    // Array write and registered read
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata <= '0;
        end else begin
            rdata <= mem[raddr];
        end
    end
endmodule

// ### verilog/tef_match.sv
/*
 Compares one stored entry with a virtual address and forms the
 physical address. Purely combinational; fed from a registered read.
*/
`timescale 1ns/100ps
module tef_match
    import tef_pkg::*;
(
    input  tef_entry_t        ent,
    input  wire logic [63:0]  va,
    input  wire logic [7:0]   address_space_identifier,
    input  wire logic         mode64,
    output logic              hit,
    output logic              odd,
    output logic [31:0]       paddr
);
    logic [26:0] keep;
    logic [31:0] offmask;
    tef_lo_t     sel;

    always_comb begin
        keep = ~{15'h0000, ent.mask};
        hit = (((ent.paired_virtual_page ^ va[39:13]) & keep) == 27'h0000000)
            && (ent.g || (ent.address_space_identifier == address_space_identifier))
            && (!mode64 || (ent.region == va[63:62]));
        odd = va[12];
        for (int i = 0; i < 12; i++) begin
            if (ent.mask[i]) begin
                odd = va[13 + i];
            end
        end
        sel = odd ? ent.lo1 : ent.lo0;
        offmask = {8'h00, ent.mask, 12'hFFF};
        paddr = ({sel.page_frame_number, 12'h000} & ~offmask) | (va[31:0] & offmask);
    end
endmodule

// ### verilog/tef_tlb.sv
/*
 Translation entry staging registers and 32-entry array with read,
 write, probe and lookup.
 Assumes operations start only while TLB_BUSY is low and that the
 index, random and wired registers live outside this block.
*/
// Overview of operation
// - Staging registers mirror every stored entry field
// - Global bit stored, reserved in high entry
// - Stored page number is address over two
// - Each entry holds eight-bit address space identifier
// - Region compared with address bits 63:62 when MODE64 is high
// - High entry fill reads zero, ignores writes
// - Reserved zero fields read zero
// - Frame number gives upper physical address bits
// - Clear dirty bit blocks writes to page
// - Global in both lows skips identifier match
// - Cache attribute two means uncached
// - Numbers 0,1,2,3,5,6,10 for mapping registers
// - Numbers 15,16,17,28,29 for remaining registers
// - Even low for even page, odd low odd
// - Mask selects page size over bits 24:13
// - Faults load high entry with failing page
`timescale 1ns/100ps
module tef_tlb
    import tef_pkg::*;
(
    input  wire logic        MCLK,
    input  wire logic        SYS_RST,
    input  wire logic        MODE64,
    input  wire logic [4:0]  REG_NUM,
    input  wire logic        REG_WR,
    input  wire logic [63:0] REG_WDATA,
    input  wire logic        REG_RD,
    output logic      [63:0] REG_RDATA,
    input  wire logic        TLB_READ,
    input  wire logic        TLB_WRITE,
    input  wire logic        TLB_PROBE,
    input  wire logic [4:0]  TLB_INDEX,
    output logic             TLB_BUSY,
    output logic             PROBE_DONE,
    output logic             PROBE_HIT,
    output logic      [4:0]  PROBE_INDEX,
    input  wire logic        LK_REQ,
    input  wire logic [63:0] LK_VADDR,
    input  wire logic        LK_STORE,
    output logic             LK_DONE,
    output logic      [31:0] LK_PADDR,
    output logic             LK_UNCACHED,
    output logic             LK_REFILL,
    output logic             LK_INVALID,
    output logic             LK_MODIFIED
);
    typedef struct packed {
        tef_state_e  st;
        logic        busy;
        logic [5:0]  cnt;
        logic [4:0]  last;
        logic        seen;
        logic        probe;
        logic        store;
        logic [63:0] va;
        logic [1:0]  hi_region;
        logic [26:0] hi_paired_virtual_page;
        logic [7:0]  hi_address_space_identifier;
        tef_lo_t     lo0;
        tef_lo_t     lo1;
        logic [11:0] mask;
        logic [63:0] rdata;
        logic        lk_done;
        logic        refill;
        logic        invalid;
        logic        modified;
        logic        uncached;
        logic [31:0] paddr;
        logic        pr_done;
        logic        pr_hit;
        logic [4:0]  pr_idx;
    } tef_regs_t;

    tef_regs_t   s;
    tef_regs_t   next_s;
    tef_entry_t  wr_ent;
    tef_entry_t  rd_ent;
    logic        mem_we;
    logic [4:0]  mem_raddr;
    logic        hit;
    logic        odd;
    logic [31:0] pa;
    tef_lo_t     sel;
    logic        fin;

    // ==========================================================
    // Entry array and comparator
    tef_mem u_mem (
        .clk   (MCLK),
        .rst   (SYS_RST),
        .we    (mem_we),
        .waddr (TLB_INDEX),
        .wdata (wr_ent),
        .raddr (mem_raddr),
        .rdata (rd_ent)
    );

    tef_match u_match (
        .ent    (rd_ent),
        .va     (s.va),
        .address_space_identifier   (s.hi_address_space_identifier),
        .mode64 (MODE64),
        .hit    (hit),
        .odd    (odd),
        .paddr  (pa)
    );

    // ==========================================================
    // Register read formatting
    function automatic logic [63:0] lo_word(input tef_lo_t lo);
        lo_word = {38'h0, lo.page_frame_number, lo.c, lo.d, lo.v, lo.g};
    endfunction

    function automatic tef_lo_t lo_load(input logic [63:0] w);
        lo_load = w[25:0];
    endfunction

    // ==========================================================
    // Next-state logic
    always_comb begin
        next_s = s;
        next_s.lk_done = 1'b0;
        next_s.pr_done = 1'b0;
        sel = odd ? rd_ent.lo1 : rd_ent.lo0;
        fin = 1'b0;
        wr_ent.mask = s.mask;
        wr_ent.region = s.hi_region;
        wr_ent.paired_virtual_page = s.hi_paired_virtual_page;
        wr_ent.g = s.lo0.g & s.lo1.g;
        wr_ent.address_space_identifier = s.hi_address_space_identifier;
        wr_ent.lo0 = s.lo0;
        wr_ent.lo1 = s.lo1;
        mem_we = (s.st == ST_IDLE) && TLB_WRITE;
        mem_raddr = (s.st == ST_SCAN) ? s.cnt[4:0] : TLB_INDEX;
        // Register numbers outside this block read as zero
        if (!REG_RD) begin
            next_s.rdata = s.rdata;
        end else if (REG_NUM == NUM_LO0) begin
            next_s.rdata = lo_word(s.lo0);
        end else if (REG_NUM == NUM_LO1) begin
            next_s.rdata = lo_word(s.lo1);
        end else if (REG_NUM == NUM_MASK) begin
            next_s.rdata = {39'h0, s.mask, 13'h0000};
        end else if (REG_NUM == NUM_HI) begin
            next_s.rdata = {s.hi_region, 22'h000000, s.hi_paired_virtual_page, 5'h00, s.hi_address_space_identifier};
        end else begin
            next_s.rdata = RST_DATA;
        end
        // Software writes; fill and reserved bits are dropped
        if (REG_WR) begin
            if (REG_NUM == NUM_LO0) begin
                next_s.lo0 = lo_load(REG_WDATA);
            end else if (REG_NUM == NUM_LO1) begin
                next_s.lo1 = lo_load(REG_WDATA);
            end else if (REG_NUM == NUM_MASK) begin
                next_s.mask = REG_WDATA[24:13];
            end else if (REG_NUM == NUM_HI) begin
                next_s.hi_region = REG_WDATA[63:62];
                next_s.hi_paired_virtual_page = REG_WDATA[39:13];
                next_s.hi_address_space_identifier = REG_WDATA[7:0];
            end
        end
        case (s.st)
            ST_IDLE: begin
                next_s.cnt = SCAN_START;
                next_s.seen = 1'b0;
                if (TLB_WRITE) begin
                    next_s.st = ST_IDLE;
                end else if (TLB_READ) begin
                    next_s.st = ST_READ;
                end else if (TLB_PROBE) begin
                    next_s.st = ST_SCAN;
                    next_s.probe = 1'b1;
                    next_s.store = 1'b0;
                    next_s.va = {s.hi_region, 22'h000000, s.hi_paired_virtual_page, 13'h0000};
                end else if (LK_REQ) begin
                    next_s.st = ST_SCAN;
                    next_s.probe = 1'b0;
                    next_s.store = LK_STORE;
                    next_s.va = LK_VADDR;
                end
            end
            ST_READ: begin
                next_s.st = ST_IDLE;
                next_s.mask = rd_ent.mask;
                next_s.hi_region = rd_ent.region;
                next_s.hi_paired_virtual_page = rd_ent.paired_virtual_page;
                next_s.hi_address_space_identifier = rd_ent.address_space_identifier;
                next_s.lo0 = rd_ent.lo0;
                next_s.lo1 = rd_ent.lo1;
                next_s.lo0.g = rd_ent.g;
                next_s.lo1.g = rd_ent.g;
            end
            ST_SCAN: begin
                next_s.cnt = s.cnt + 6'h01;
                next_s.last = s.cnt[4:0];
                next_s.seen = 1'b1;
                fin = s.seen && (hit || (s.last == SCAN_LAST));
                if (fin) begin
                    next_s.st = ST_IDLE;
                    if (s.probe) begin
                        next_s.pr_done = 1'b1;
                        next_s.pr_hit = hit;
                        next_s.pr_idx = s.last;
                    end else begin
                        next_s.lk_done = 1'b1;
                        next_s.refill = !hit;
                        next_s.invalid = hit && !sel.v;
                        next_s.modified = hit && sel.v && s.store && !sel.d;
                        next_s.uncached = hit && (sel.c == C_UNCACHED);
                        next_s.paddr = hit ? pa : 32'h00000000;
                        if (!hit || !sel.v || (s.store && !sel.d)) begin
                            next_s.hi_region = s.va[63:62];
                            next_s.hi_paired_virtual_page = s.va[39:13];
                        end
                    end
                end
            end
            default: begin
                next_s.st = ST_IDLE;
            end
        endcase
        next_s.busy = (next_s.st != ST_IDLE);
    end

    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // ==========================================================
    // Outputs
    assign REG_RDATA   = s.rdata;
    assign TLB_BUSY    = s.busy;
    assign PROBE_DONE  = s.pr_done;
    assign PROBE_HIT   = s.pr_hit;
    assign PROBE_INDEX = s.pr_idx;
    assign LK_DONE     = s.lk_done;
    assign LK_PADDR    = s.paddr;
    assign LK_UNCACHED = s.uncached;
    assign LK_REFILL   = s.refill;
    assign LK_INVALID  = s.invalid;
    assign LK_MODIFIED = s.modified;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (SYS_RST);

    sequence s_lk_start;
        s.st == ST_IDLE && !TLB_WRITE && !TLB_READ && !TLB_PROBE && LK_REQ;
    endsequence
    sequence s_lk_end;
        ##[3:34] LK_DONE;
    endsequence

    property p_lk_bound;
        s_lk_start |-> s_lk_end;
    endproperty
    a_lk_bound: assert property (p_lk_bound) else $error("lookup did not finish");

    property p_hi_fill;
        REG_RD && REG_NUM == NUM_HI |=> REG_RDATA[61:40] == 22'h000000 && REG_RDATA[12:8] == 5'h00;
    endproperty
    a_hi_fill: assert property (p_hi_fill) else $error("high entry fill not zero");

    property p_lo_rsvd;
        REG_RD && REG_NUM == NUM_LO1 |=> REG_RDATA[63:26] == 38'h0;
    endproperty
    a_lo_rsvd: assert property (p_lo_rsvd) else $error("low entry reserved not zero");

    property p_mask_rd;
        REG_RD && REG_NUM == NUM_MASK |=> REG_RDATA[24:13] == $past(s.mask) && REG_RDATA[12:0] == 13'h0000;
    endproperty
    a_mask_rd: assert property (p_mask_rd) else $error("mask readback wrong");

    property p_global;
        mem_we |-> wr_ent.g == (s.lo0.g && s.lo1.g);
    endproperty
    a_global: assert property (p_global) else $error("global bit not anded");

    property p_uncached;
        fin && !s.probe && hit && sel.c == C_UNCACHED |=> LK_UNCACHED && LK_DONE;
    endproperty
    a_uncached: assert property (p_uncached) else $error("uncached attribute lost");

    property p_modified;
        LK_DONE && LK_MODIFIED |-> !LK_INVALID && !LK_REFILL && $past(s.store);
    endproperty
    a_modified: assert property (p_modified) else $error("modified fault without store");

    property p_invalid;
        fin && !s.probe && hit && !sel.v |=> LK_INVALID ##1 !LK_DONE;
    endproperty
    a_invalid: assert property (p_invalid) else $error("invalid fault missing");

    property p_fault_hi;
        LK_DONE && (LK_REFILL || LK_INVALID || LK_MODIFIED) |-> s.hi_paired_virtual_page == s.va[39:13]
            && s.hi_region == s.va[63:62];
    endproperty
    a_fault_hi: assert property (p_fault_hi) else $error("high entry not loaded on fault");
endmodule

// ### test/tef_tlb_tb_top.sv
/*
 Self-checking bench for the translation entry block: staging registers,
 entry write, read, probe and lookup.
 Assumes the block alone on one 250 MHz clock, driven 1 ns after each edge.
*/
`timescale 1ns/100ps
module tef_tlb_tb_top
    import tef_pkg::*;
;
    // ==========================================================
    // Signals and instance
    logic        MCLK = 1'b0;
    logic        SYS_RST = 1'b1;
    logic        MODE64 = 1'b1;
    logic [4:0]  REG_NUM = 5'h00;
    logic        REG_WR = 1'b0;
    logic [63:0] REG_WDATA = 64'h0;
    logic        REG_RD = 1'b0;
    logic [63:0] REG_RDATA;
    logic        TLB_READ = 1'b0;
    logic        TLB_WRITE = 1'b0;
    logic        TLB_PROBE = 1'b0;
    logic [4:0]  TLB_INDEX = 5'h00;
    logic        TLB_BUSY;
    logic        PROBE_DONE;
    logic        PROBE_HIT;
    logic [4:0]  PROBE_INDEX;
    logic        LK_REQ = 1'b0;
    logic [63:0] LK_VADDR = 64'h0;
    logic        LK_STORE = 1'b0;
    logic        LK_DONE;
    logic [31:0] LK_PADDR;
    logic        LK_UNCACHED;
    logic        LK_REFILL;
    logic        LK_INVALID;
    logic        LK_MODIFIED;
    int          error_cnt = 0;
    int          num_checks = 0;

    always #2 MCLK = ~MCLK;

    tef_tlb tef_tlb_i (.MCLK(MCLK), .SYS_RST(SYS_RST), .MODE64(MODE64), .REG_NUM(REG_NUM),
        .REG_WR(REG_WR), .REG_WDATA(REG_WDATA), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
        .TLB_READ(TLB_READ), .TLB_WRITE(TLB_WRITE), .TLB_PROBE(TLB_PROBE), .TLB_INDEX(TLB_INDEX),
        .TLB_BUSY(TLB_BUSY), .PROBE_DONE(PROBE_DONE), .PROBE_HIT(PROBE_HIT), .PROBE_INDEX(PROBE_INDEX),
        .LK_REQ(LK_REQ), .LK_VADDR(LK_VADDR), .LK_STORE(LK_STORE), .LK_DONE(LK_DONE),
        .LK_PADDR(LK_PADDR), .LK_UNCACHED(LK_UNCACHED), .LK_REFILL(LK_REFILL),
        .LK_INVALID(LK_INVALID), .LK_MODIFIED(LK_MODIFIED));

    // ==========================================================
    // Helpers
    function automatic logic [63:0] lo(logic [19:0] page_frame_number, logic [2:0] c, logic d, logic v, logic g);
        return {38'h0, page_frame_number, c, d, v, g};
    endfunction
    function automatic logic [63:0] hi(logic [1:0] r, logic [26:0] paired_virtual_page, logic [7:0] address_space_identifier);
        return {r, 22'h0, paired_virtual_page, 5'h00, address_space_identifier};
    endfunction
    function automatic logic [63:0] va(logic [1:0] r, logic [26:0] paired_virtual_page, logic odd, logic [11:0] off);
        return {r, 22'h0, paired_virtual_page, odd, off};
    endfunction

    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic fire();
        @(posedge MCLK);
        #1;
        REG_WR = 1'b0;
        REG_RD = 1'b0;
        TLB_READ = 1'b0;
        TLB_WRITE = 1'b0;
        TLB_PROBE = 1'b0;
        LK_REQ = 1'b0;
        // Idle edge so the next request never sets a strobe in this step
        @(posedge MCLK);
        #1;
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        while (TLB_BUSY !== 1'b0 && n < 40) begin
            @(posedge MCLK);
            #1;
            n++;
        end
        if (n == 40) begin
            check("busy timeout", 64'(TLB_BUSY), 64'h0);
            print_verdict();
        end
    endtask
    task automatic reg_wr(input logic [4:0] num, input logic [63:0] data);
        REG_NUM = num;
        REG_WDATA = data;
        REG_WR = 1'b1;
        fire();
    endtask
    task automatic reg_chk(input string what, input logic [4:0] num, input logic [63:0] exp);
        REG_NUM = num;
        REG_RD = 1'b1;
        fire();
        check(what, REG_RDATA, exp);
    endtask
    task automatic load(input logic [4:0] idx, input logic [63:0] h, l0, l1, m);
        reg_wr(NUM_HI, h);
        reg_wr(NUM_LO0, l0);
        reg_wr(NUM_LO1, l1);
        reg_wr(NUM_MASK, m);
        TLB_INDEX = idx;
        TLB_WRITE = 1'b1;
        fire();
    endtask
    // Flags order: uncached, refill, invalid, modified; address skipped when all ones
    task automatic lk(input string what, input logic [63:0] a, input logic st, input logic [31:0] pa,
                      input logic [3:0] fl);
        LK_VADDR = a;
        LK_STORE = st;
        LK_REQ = 1'b1;
        fire();
        wait_idle();
        check(what, 64'(LK_DONE), 64'h1);
        check(what, 64'({LK_UNCACHED, LK_REFILL, LK_INVALID, LK_MODIFIED}), 64'(fl));
        if (pa !== 32'hFFFF_FFFF) begin
            check(what, 64'(LK_PADDR), 64'(pa));
        end
    endtask
    task automatic pr(input logic [63:0] h, input logic hit, input logic [4:0] idx);
        reg_wr(NUM_HI, h);
        TLB_PROBE = 1'b1;
        fire();
        wait_idle();
        check("probe", 64'({PROBE_DONE, PROBE_HIT}), 64'({1'b1, hit}));
        if (hit) begin
            check("probe index", 64'(PROBE_INDEX), 64'(idx));
        end
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_regs();
        logic [4:0]  num [4] = '{NUM_LO0, NUM_LO1, NUM_MASK, NUM_HI};
        logic [63:0] wrv [4] = '{64'h3FF_FFFF, 64'h3FF_FFFF, 64'h1FF_E000, 64'hFFFF_FFFF_FFFF_E0FF};
        logic [63:0] msk [4] = '{64'h3FF_FFFF, 64'h3FF_FFFF, 64'h1FF_E000, 64'hC000_00FF_FFFF_E0FF};
        logic [4:0]  oth [8] = '{NUM_INDEX, NUM_RANDOM, NUM_WIRED, NUM_PROCESSOR_IDENTIFICATION, NUM_CONFIG, NUM_LINK,
                                 NUM_CACHE_TAG_LOW, NUM_CACHE_TAG_HIGH};
        check("idle outputs", 64'({TLB_BUSY, PROBE_DONE, LK_DONE, LK_REFILL, LK_PADDR}), 64'h0);
        reg_chk("high after reset", NUM_HI, 64'h0);
        for (int i = 0; i < 4; i++) begin
            // Reserved zero bits are written as zero; ones go to the fields and to the high entry fill bits
            reg_wr(num[i], wrv[i]);
            reg_chk("reserved bits", num[i], msk[i]);
            reg_wr(num[i], 64'h0);
            reg_chk("cleared", num[i], 64'h0);
        end
        for (int i = 0; i < 8; i++) begin
            reg_wr(oth[i], '1);
            reg_chk("foreign number", oth[i], 64'h0);
        end
    endtask
    task automatic t_fill();
        for (int i = 0; i < 32; i++) begin
            load(5'(i), hi(2'h2, 27'h700_0000 | 27'(i), 8'hFF), 64'h0, 64'h0, 64'h0);
        end
        load(5'h03, hi(2'h0, 27'h12, 8'h05), lo(20'hABCDE, 3'h3, 1'b1, 1'b1, 1'b1),
             lo(20'h12345, 3'h2, 1'b0, 1'b1, 1'b0), 64'h0);
        load(5'h07, hi(2'h3, 27'h40, 8'h00), lo(20'h00111, 3'h0, 1'b1, 1'b0, 1'b1),
             lo(20'h00777, 3'h0, 1'b1, 1'b1, 1'b1), 64'h0);
        load(5'h0B, hi(2'h0, 27'h100, 8'h05), lo(20'h0AAA0, 3'h3, 1'b1, 1'b1, 1'b0),
             lo(20'h0BBB0, 3'h3, 1'b1, 1'b1, 1'b0), 64'h6000);
    endtask
    task automatic t_lookup();
        reg_wr(NUM_HI, hi(2'h0, 27'h0, 8'h05));
        lk("even load", va(2'h0, 27'h12, 1'b0, 12'h345), 1'b0, 32'hABCDE345, 4'b0000);
        lk("odd store clean", va(2'h0, 27'h12, 1'b1, 12'h345), 1'b1, 32'hFFFF_FFFF, 4'b1001);
        lk("odd load", va(2'h0, 27'h12, 1'b1, 12'hABC), 1'b0, 32'h12345ABC, 4'b1000);
        lk("even store dirty", va(2'h0, 27'h12, 1'b0, 12'h345), 1'b1, 32'hABCDE345, 4'b0000);
        lk("large page", va(2'h0, 27'h102, 1'b1, 12'h234), 1'b0, 32'h0BBB1234, 4'b0000);
        reg_wr(NUM_HI, hi(2'h0, 27'h0, 8'h06));
        lk("other process", va(2'h0, 27'h12, 1'b0, 12'h000), 1'b0, 32'h0, 4'b0100);
        reg_chk("fault page", NUM_HI, hi(2'h0, 27'h12, 8'h06));
        lk("global", va(2'h3, 27'h40, 1'b1, 12'h010), 1'b0, 32'h00777010, 4'b0000);
        lk("invalid", va(2'h3, 27'h40, 1'b0, 12'h010), 1'b0, 32'hFFFF_FFFF, 4'b0010);
        lk("region", va(2'h1, 27'h40, 1'b1, 12'h010), 1'b0, 32'h0, 4'b0100);
        reg_chk("fault region", NUM_HI, hi(2'h1, 27'h40, 8'h06));
        MODE64 = 1'b0;
        lk("region ignored", va(2'h1, 27'h40, 1'b1, 12'h010), 1'b0, 32'h00777010, 4'b0000);
        MODE64 = 1'b1;
    endtask
    task automatic t_probe();
        pr(hi(2'h3, 27'h40, 8'h06), 1'b1, 5'h07);
        pr(hi(2'h0, 27'h12, 8'h05), 1'b1, 5'h03);
        pr(hi(2'h0, 27'h12, 8'h09), 1'b0, 5'h00);
        pr(hi(2'h0, 27'h101, 8'h05), 1'b1, 5'h0B);
    endtask
    task automatic t_read();
        TLB_INDEX = 5'h03;
        TLB_READ = 1'b1;
        fire();
        wait_idle();
        reg_chk("read lo0", NUM_LO0, lo(20'hABCDE, 3'h3, 1'b1, 1'b1, 1'b0));
        reg_chk("read lo1", NUM_LO1, lo(20'h12345, 3'h2, 1'b0, 1'b1, 1'b0));
        reg_chk("read hi", NUM_HI, hi(2'h0, 27'h12, 8'h05));
        TLB_INDEX = 5'h0B;
        TLB_READ = 1'b1;
        fire();
        wait_idle();
        reg_chk("read mask", NUM_MASK, 64'h6000);
        reg_chk("read lo1 b", NUM_LO1, lo(20'h0BBB0, 3'h3, 1'b1, 1'b1, 1'b0));
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        repeat (4) @(posedge MCLK);
        #1;
        SYS_RST = 1'b0;
        t_regs();
        t_fill();
        t_lookup();
        t_probe();
        t_read();
        print_verdict();
    end
endmodule
